// [hdl/hrp_host_port.sv]
/*
 * host register port: serial frame decoder, parallel port and a small
 * register store. assumes serial and parallel pins are synchronous to
 * ref_clk_i and the serial clock is far slower than it.
 */
`timescale 1ns/100ps
`default_nettype none
`include "hrp_defines.svh"

module hrp_host_port (
	input  wire logic               ref_clk_i,
	input  wire logic               resetn_i,
	input  wire logic               chip_sel_n_i,
	input  wire logic               serial_clk_i,
	input  wire logic               serial_data_in_i,
	output logic                    serial_data_out_o,
	output logic                    serial_data_out_oe_o,
	input  wire logic               par_sel_n_i,
	input  wire logic               par_rd_n_i,
	input  wire logic               data_strobe_n_i,
	input  wire hrp_pkg::hrp_addr_t par_addr_i,
	input  wire hrp_pkg::hrp_data_t par_data_i,
	output hrp_pkg::hrp_data_t      par_data_o,
	output logic                    par_data_oe_o,
	output logic                    par_ack_o
);
	// -------------------------------------------------------------
	// reset release
	// -------------------------------------------------------------
	logic rst_q1;
	logic rst_n;
	// two stages so release is clean against ref_clk_i
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rst_q1 <= 1'b0;
			rst_n  <= 1'b0;
		end else begin
			rst_q1 <= 1'b1;
			rst_n  <= rst_q1;
		end
	end

	// -------------------------------------------------------------
	// serial edges
	// -------------------------------------------------------------
	logic sclk_d;
	logic cs_d;
	logic sclk_rise;
	logic sclk_fall;
	logic frame_on;
	assign sclk_rise = serial_clk_i && !sclk_d;
	assign sclk_fall = !serial_clk_i && sclk_d;
	assign frame_on  = !chip_sel_n_i;

	// delayed copies for edge detection
	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			sclk_d <= 1'b0;
			cs_d   <= 1'b1;
		end else begin
			sclk_d <= serial_clk_i;
			cs_d   <= chip_sel_n_i;
		end
	end

	// -------------------------------------------------------------
	// serial frame engine
	// -------------------------------------------------------------
	hrp_pkg::hrp_state_e state;
	logic [`HRP_HDR_BITS-1:0] hdr;
	logic [4:0]               bit_cnt;
	hrp_pkg::hrp_data_t       wshift;
	hrp_pkg::hrp_data_t       rshift;
	logic                     is_read;
	logic                     ser_we;
	hrp_pkg::hrp_addr_t       ser_addr;
	hrp_pkg::hrp_data_t       ser_wdata;
	hrp_pkg::hrp_data_t       ser_rdata;
	assign is_read = hdr[`HRP_HDR_BITS-1];

	// state: a raised chip select aborts any partial frame
	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			state <= hrp_pkg::HRP_IDLE;
		end else if (!frame_on) begin
			state <= hrp_pkg::HRP_IDLE;
		end else begin
			case (state)
				hrp_pkg::HRP_IDLE: state <= hrp_pkg::HRP_HDR;
				hrp_pkg::HRP_HDR: begin
					if (sclk_rise && bit_cnt == 5'(`HRP_HDR_BITS - 1)) begin
						// the first bit of the frame sits one below the top here,
						// because the last address bit shifts in on this same edge
						state <= hdr[`HRP_HDR_BITS-2] ? hrp_pkg::HRP_RDATA
							: hrp_pkg::HRP_WDATA;
					end
				end
				hrp_pkg::HRP_WDATA: state <= hrp_pkg::HRP_WDATA;
				hrp_pkg::HRP_RDATA: state <= hrp_pkg::HRP_RDATA;
				default: state <= hrp_pkg::HRP_IDLE;
			endcase
		end
	end

	// bit counter and input shifter, msb first
	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			bit_cnt <= 5'h00;
			hdr     <= 16'h0000;
			wshift  <= 8'h00;
		end else if (!frame_on) begin
			bit_cnt <= 5'h00;
		end else if (sclk_rise && bit_cnt != 5'(`HRP_FRAME_BITS)) begin
			bit_cnt <= bit_cnt + 5'h01;
			if (bit_cnt < 5'(`HRP_HDR_BITS)) begin
				hdr <= {hdr[`HRP_HDR_BITS-2:0], serial_data_in_i};
			end else begin
				wshift <= {wshift[`HRP_DATA_BITS-2:0], serial_data_in_i};
			end
		end
	end

	// write commit on the last data bit
	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			ser_we    <= 1'b0;
			ser_wdata <= 8'h00;
		end else begin
			ser_we <= frame_on && state == hrp_pkg::HRP_WDATA && sclk_rise
				&& bit_cnt == 5'(`HRP_FRAME_BITS - 1);
			ser_wdata <= {wshift[`HRP_DATA_BITS-2:0], serial_data_in_i};
		end
	end
	assign ser_addr = hdr[`HRP_ADDR_BITS-1:0];

	// read shifter: loads at header end, moves on falling clock
	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			rshift               <= 8'h00;
			serial_data_out_o    <= 1'b0;
			serial_data_out_oe_o <= 1'b0;
		end else if (!frame_on) begin
			serial_data_out_oe_o <= 1'b0;
		end else if (state == hrp_pkg::HRP_RDATA) begin
			if (sclk_fall) begin
				serial_data_out_oe_o <= 1'b1;
				serial_data_out_o    <= rshift[`HRP_DATA_BITS-1];
				rshift <= {rshift[`HRP_DATA_BITS-2:0], 1'b0};
			end else if (!serial_data_out_oe_o) begin
				// reload until the first falling edge: only now does the
				// header hold the complete address
				rshift <= ser_rdata;
			end
		end else begin
			rshift <= ser_rdata;
		end
	end

	// -------------------------------------------------------------
	// parallel port and register store
	// -------------------------------------------------------------
	logic               par_we;
	hrp_pkg::hrp_addr_t par_waddr;
	hrp_pkg::hrp_data_t par_wdata;
	hrp_pkg::hrp_data_t par_rdata;
	hrp_pkg::hrp_data_t regs [0:255];

	hrp_par_port u_par (
		.ref_clk_i (ref_clk_i),
		.rst_n_i   (rst_n),
		.sel_n_i   (par_sel_n_i),
		.rd_n_i    (par_rd_n_i),
		.wr_n_i    (data_strobe_n_i),
		.addr_i    (par_addr_i),
		.wdata_i   (par_data_i),
		.rdata_i   (par_rdata),
		.we_o      (par_we),
		.waddr_o   (par_waddr),
		.wdata_o   (par_wdata),
		.ack_o     (par_ack_o),
		.dout_o    (par_data_o),
		.dout_oe_o (par_data_oe_o)
	); // kept by the port: write ignored while read strobe low

	// store limited to 256 words to bound area; upper address bits alias
	assign ser_rdata = regs[ser_addr[7:0]];
	assign par_rdata = regs[par_addr_i[7:0]];
	always_ff @(posedge ref_clk_i) begin
		if (ser_we) begin
			regs[ser_addr[7:0]] <= ser_wdata;
		end else if (par_we) begin
			regs[par_waddr[7:0]] <= par_wdata;
		end
	end

	// -------------------------------------------------------------
	// checks
	// -------------------------------------------------------------
	sequence s_frame_up;
		cs_d && frame_on;
	endsequence
	a_frame_start: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
		s_frame_up |-> bit_cnt == 5'h00) else $error("frame count not cleared");
	a_cs_abort: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
		chip_sel_n_i |=> state == hrp_pkg::HRP_IDLE && !serial_data_out_oe_o)
		else $error("frame not ended");
	a_dir_read: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
		frame_on && state == hrp_pkg::HRP_HDR && $past(frame_on)
		##1 state == hrp_pkg::HRP_WDATA |-> !is_read) else $error("wrong direction");
	a_sdo_falling: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
		!$stable(serial_data_out_o) |-> $past(sclk_fall)) else $error("sdo moved off edge");
	a_write_read: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
		ser_we |-> state == hrp_pkg::HRP_WDATA) else $error("write outside frame");
	a_hdr_len: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
		state == hrp_pkg::HRP_HDR ##1 state == hrp_pkg::HRP_RDATA
		|-> bit_cnt == 5'(`HRP_HDR_BITS)) else $error("header length");
	a_no_wr_rd: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
		ser_we |-> !is_read) else $error("write in read frame");
endmodule : hrp_host_port
`default_nettype wire

// [hdl/hrp_par_port.sv]
/*
 * parallel strobe port: one access per strobe, answered by acknowledge and
 * data bus release. assumes synchronous host strobes, one style at a time.
 */
`timescale 1ns/100ps
`default_nettype none
`include "hrp_defines.svh"

module hrp_par_port (
	input  wire logic              ref_clk_i,
	input  wire logic              rst_n_i,
	input  wire logic              sel_n_i,
	input  wire logic              rd_n_i,
	input  wire logic              wr_n_i,
	input  wire hrp_pkg::hrp_addr_t addr_i,
	input  wire hrp_pkg::hrp_data_t wdata_i,
	input  wire hrp_pkg::hrp_data_t rdata_i,
	output logic                   we_o,
	output hrp_pkg::hrp_addr_t     waddr_o,
	output hrp_pkg::hrp_data_t     wdata_o,
	output logic                   ack_o,
	output hrp_pkg::hrp_data_t     dout_o,
	output logic                   dout_oe_o
);
	// release window in core cycles, held as an int so it can bound a delay range
	localparam int ZRD_CYC = `HRP_ZRD_CYC;
	logic rd_act;
	logic wr_act;
	logic wr_seen;
	assign rd_act = !sel_n_i && !rd_n_i;
	assign wr_act = !sel_n_i && !wr_n_i && rd_n_i;

	// write commits once per strobe; a short strobe still lands
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wr_seen <= 1'b0;
			we_o    <= 1'b0;
			waddr_o <= 11'h000;
			wdata_o <= 8'h00;
		end else begin
			wr_seen <= wr_act;
			we_o    <= wr_act && !wr_seen;
			if (wr_act && !wr_seen) begin
				waddr_o <= addr_i;
				wdata_o <= wdata_i;
			end
		end
	end

	// acknowledge follows the strobe; host may wait on it or not
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ack_o <= 1'b0;
		end else begin
			// raised on the same edge as the write commit, so a host that waits
			// on it never releases the strobe before the write has been taken
			ack_o <= wr_act || rd_act;
		end
	end

	// read data and bus release: enable drops one edge after negation
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			dout_o    <= 8'h00;
			dout_oe_o <= 1'b0;
		end else begin
			dout_oe_o <= rd_act;
			if (rd_act) begin
				dout_o <= rdata_i;
			end
		end
	end

	a_bus_release: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		!rd_act |-> ##[1:ZRD_CYC] !dout_oe_o) else $error("bus not released");
	a_write_once: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		we_o |=> !we_o) else $error("write repeated");
	a_ack_write: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		we_o |-> ack_o) else $error("no ack on write");
endmodule : hrp_par_port
`default_nettype wire

// [pkg/hrp_defines.svh]
/*
 * timing counts, field widths and widths of the host register port.
 * assumes a 100 MHz core clock; included by bare name.
 */
`ifndef HRP_DEFINES_SVH
`define HRP_DEFINES_SVH

`define HRP_INSTR_BITS   5
`define HRP_ADDR_BITS    11
`define HRP_DATA_BITS    8
`define HRP_HDR_BITS     16
`define HRP_FRAME_BITS   24
`define HRP_READ_BIT     4
`define HRP_CLK_NS       10
`define HRP_WSTB_MIN_NS  5
`define HRP_WSTB_CYC     ((`HRP_WSTB_MIN_NS + `HRP_CLK_NS - 1) / `HRP_CLK_NS)
`define HRP_ZRD_MAX_NS   20
`define HRP_ZRD_CYC      (`HRP_ZRD_MAX_NS / `HRP_CLK_NS)

`endif

// [pkg/hrp_pkg.sv]
/*
 * types shared by the host register port files.
 * assumes hrp_defines.svh is on the include path.
 */
`include "hrp_defines.svh"

package hrp_pkg;
	typedef enum logic [1:0] {
		HRP_IDLE  = 2'b00,
		HRP_HDR   = 2'b01,
		HRP_WDATA = 2'b10,
		HRP_RDATA = 2'b11
	} hrp_state_e;
	typedef logic [`HRP_ADDR_BITS-1:0] hrp_addr_t;
	typedef logic [`HRP_DATA_BITS-1:0] hrp_data_t;
endpackage : hrp_pkg

// [test/hrp_host_model.sv]
/*
 * serial host model: drives chip select, serial clock and data in.
 * assumes ref_clk_i is the 100 MHz core clock of the port.
 */
`timescale 1ns/100ps
`default_nettype none
module hrp_host_model (
	input  wire logic ref_clk_i,
	input  wire logic sdo_i,
	input  wire logic sdo_oe_i,
	output logic      cs_n_o,
	output logic      sclk_o,
	output logic      sdi_o
);
	localparam int HALF = 25; // 500 ns period, the 2 MHz ceiling
	// ----
	// frame of up to 24 bits; fewer bits abort it
	// ----
	task automatic frame(input logic [23:0] bits, input int n,
			output hrp_pkg::hrp_data_t q, output logic ok);
		q = 8'h00;
		ok = 1'b1;
		@(negedge ref_clk_i);
		cs_n_o = 1'b0;
		for (int i = 0; i < n; i++) begin
			sdi_o = bits[23-i];
			repeat (HALF) @(negedge ref_clk_i);
			// read bits settle after the falling edge, so take them just before rising
			if (i >= 16) begin
				q = {q[6:0], sdo_i};
				ok &= (sdo_oe_i === 1'b1);
			end
			sclk_o = 1'b1;
			repeat (HALF) @(negedge ref_clk_i);
			sclk_o = 1'b0; // clock stands still low outside frames
		end
		sdi_o = ~sdi_o; // no stale bit left on the line
		repeat (HALF) @(negedge ref_clk_i);
		cs_n_o = 1'b1;
		repeat (HALF) @(negedge ref_clk_i);
	endtask : frame
	// idle levels
	initial begin
		cs_n_o = 1'b1;
		sclk_o = 1'b0;
		sdi_o = 1'b0;
	end
endmodule : hrp_host_model
`default_nettype wire

// [test/tb_top.sv]
/*
 * self-checking bench: serial frames via the host model, parallel strobes
 * from here, a random mix on a fixed seed. assumes the 100 MHz clock.
 */
`timescale 1ns/100ps
`default_nettype none
`include "hrp_defines.svh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin fails++; \
	$display("CHECK FAILED %0t got %h exp %h", $time, g, e); end end
module tb_top;
	logic               ref_clk_i, resetn_i, cs_n, sclk, serial_data_in, serial_data_out, sdo_oe;
	logic               par_sel_n, par_rd_n, wr_n, ack, dout_oe;
	hrp_pkg::hrp_addr_t par_addr;
	hrp_pkg::hrp_data_t par_wdata, dout;
	hrp_pkg::hrp_data_t mem [256];
	bit                 known [256];
	int                 fails, n_compared;
	// ----
	// clock, design and host
	// ----
	initial begin
		ref_clk_i = 1'b0;
		forever #5 ref_clk_i = ~ref_clk_i;
	end
	hrp_host_port dut_u (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .chip_sel_n_i(cs_n),
		.serial_clk_i(sclk), .serial_data_in_i(serial_data_in), .serial_data_out_o(serial_data_out),
		.serial_data_out_oe_o(sdo_oe), .par_sel_n_i(par_sel_n), .par_rd_n_i(par_rd_n),
		.data_strobe_n_i(wr_n), .par_addr_i(par_addr), .par_data_i(par_wdata),
		.par_data_o(dout), .par_data_oe_o(dout_oe), .par_ack_o(ack));
	hrp_host_model host_u (.ref_clk_i(ref_clk_i), .sdo_i(serial_data_out), .sdo_oe_i(sdo_oe),
		.cs_n_o(cs_n), .sclk_o(sclk), .sdi_o(serial_data_in));
	// ----
	// tasks
	// ----
	task automatic end_of_test;
		$display("compared %0d fails %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : end_of_test
	// bounded wait: a missing acknowledge ends the run
	task automatic wait_ack;
		int k;
		k = 0;
		do begin
			@(posedge ref_clk_i);
			#1;
			k++;
		end while (ack !== 1'b1 && k < 8);
		if (ack !== 1'b1) begin
			fails++;
			end_of_test();
		end
	endtask : wait_ack
	// strobe held until acknowledge, read strobe high all along
	task automatic pwrite(input hrp_pkg::hrp_addr_t a, input hrp_pkg::hrp_data_t d);
		@(negedge ref_clk_i);
		{par_sel_n, wr_n, par_addr, par_wdata} = {2'b00, a, d};
		wait_ack();
		@(negedge ref_clk_i);
		{par_sel_n, wr_n, par_addr, par_wdata} = {2'b11, ~a, ~d};
	endtask : pwrite
	task automatic pread(input hrp_pkg::hrp_addr_t a, output hrp_pkg::hrp_data_t d);
		@(negedge ref_clk_i);
		{par_sel_n, par_rd_n, par_addr} = {2'b00, a};
		wait_ack();
		d = dout;
		`CHK(dout_oe, 1'b1)
		@(negedge ref_clk_i);
		{par_sel_n, par_rd_n, par_addr} = {2'b11, ~a};
		repeat (`HRP_ZRD_CYC) @(posedge ref_clk_i);
		#1 `CHK(dout_oe, 1'b0)
	endtask : pread
	// kind: 0 serial write, 1 serial read, 2 parallel write, 3 parallel read
	task automatic acc(input int kind, input hrp_pkg::hrp_addr_t a,
			input hrp_pkg::hrp_data_t d, input int n);
		hrp_pkg::hrp_data_t q;
		logic ok;
		if (kind == 2) pwrite(a, d);
		else if (kind == 3) pread(a, q);
		else host_u.frame({kind[0], 4'h0, a, d}, n, q, ok);
		if (kind[0]) `CHK(q, mem[a[7:0]])
		else if (n == 24) begin
			mem[a[7:0]] = d;
			known[a[7:0]] = 1'b1;
		end
		if (kind == 1) `CHK(ok, 1'b1)
		if (kind < 2) `CHK(sdo_oe, 1'b0)
	endtask : acc
	// ----
	// main sequence
	// ----
	initial begin
		hrp_pkg::hrp_addr_t a;
		int k;
		{resetn_i, par_sel_n, par_rd_n, wr_n, par_addr, par_wdata} = {4'h7, 19'h00000};
		void'($urandom(32'h961C98B4));
		repeat (5) @(negedge ref_clk_i);
		resetn_i = 1'b1;
		repeat (4) @(negedge ref_clk_i);
		// corners: top address, all ones, both paths, then an aborted write
		acc(0, 11'h7FF, 8'hFF, 24);
		acc(3, 11'h7FF, 8'h00, 24);
		acc(2, 11'h0A5, 8'h5A, 24);
		acc(1, 11'h0A5, 8'h00, 24);
		acc(0, 11'h0A5, 8'hC3, 20); // cut short, store keeps old value
		acc(1, 11'h0A5, 8'h00, 24);
		acc(0, 11'h000, 8'h00, 24);
		acc(1, 11'h000, 8'h00, 24);
		// random mix; addresses alias on the low byte
		repeat (40) begin
			k = $urandom % 4;
			a = 11'($urandom) & 11'h707;
			if (k % 2 == 1 && !known[a[7:0]]) k = k - 1;
			acc(k, a, 8'($urandom), 24);
		end
		end_of_test();
	end
endmodule : tb_top
`default_nettype wire
